// File: ipra_target.v
// i2c target transaction logic with a page/word pointer and a cache port
// assumes scl/sda from pins (synchronised here) and a register store outside
`timescale 1ns/10ps
`default_nettype none
`include "ipra_regs.vh"
// Contract
// - a transaction opens with start then an address byte, lsb is direction
// - address 0xac is a write access and is acknowledged
// - address 0xad is a read access; after ack the device drives data
// - first written byte is the pointer: upper five page, lower three word
// - later written bytes are stored at the current word and acknowledged; the code nacks them while the write-back fifo is full
// - after each data byte the word part advances by one, page unchanged
// - a byte not acknowledged leaves the pointer unchanged
// - random read: write pointer, stop, start with read address
// - controller ack on a read byte advances the word and sends next
// - read without setting pointer returns the pointer: last location read, or last written plus one
// - controller nack ends a read; device releases the data line high
// - repeated start is not accepted; stop must come first
// - on start the cache is loaded and serves transfers until stop
// - on stop after a write the modified cache entries are written back
// - receiver pulls data low in the ninth clock to acknowledge
module ipra_target (
	input wire clk_sys,
	input wire reset,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	output reg cache_load,
	output reg [7:0] cache_addr,
	input wire [7:0] cache_rdata,
	output wire wb_valid,
	input wire wb_ready,
	output wire [15:0] wb_data,
	output reg [7:0] pointer,
	output reg busy
);
	localparam S_IDLE = 7'b0000001;
	localparam S_ADDR = 7'b0000010;
	localparam S_PTR = 7'b0000100;
	localparam S_WDATA = 7'b0001000;
	localparam S_RDATA = 7'b0010000;
	localparam S_RACK = 7'b0100000;
	localparam S_IGNORE = 7'b1000000;

	function [7:0] next_word;
		input [7:0] p;
		begin
			next_word = {p[`IPRA_PAGE_MSB:`IPRA_PAGE_LSB], p[`IPRA_WORD_MSB:`IPRA_WORD_LSB] + 3'd1};
		end
	endfunction

	reg scl_m_reg, scl_s_reg, scl_d_reg;
	reg sda_m_reg, sda_s_reg, sda_d_reg;
	reg [6:0] state_reg;
	reg [3:0] bit_reg;
	reg [7:0] shift_reg;
	reg ack_phase_reg;
	reg ack_drive_reg;
	reg tx_drive_reg;
	reg [15:0] wb_entry_reg;
	reg fifo_in_valid;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	reg [7:0] byte_in;

	assign scl_rise = scl_s_reg && !scl_d_reg;
	assign scl_fall = !scl_s_reg && scl_d_reg;
	// start/stop judged on synchronised levels, so both lines carry the same delay
	assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
	assign stop_det = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
	// open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = ack_drive_reg || tx_drive_reg;

	always @* begin
		byte_in = {shift_reg[6:0], sda_s_reg};
	end

	// the third stage only serves edge detection, never the logic directly
	always @(posedge clk_sys) begin
		scl_m_reg <= scl_in;
		scl_s_reg <= scl_m_reg;
		scl_d_reg <= scl_s_reg;
		sda_m_reg <= sda_in;
		sda_s_reg <= sda_m_reg;
		sda_d_reg <= sda_s_reg;
	end

	// write-back entries queue here; a stalled sink holds scl-side progress only by refusing acks
	ipra_fifo #(
		.WIDTH(`IPRA_FIFO_WIDTH),
		.DEPTH(`IPRA_FIFO_DEPTH),
		.AW(`IPRA_FIFO_AW)
	) u_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(wb_entry_reg),
		.out_valid(fifo_out_valid),
		.out_ready(wb_ready && !busy),
		.out_data(wb_data)
	);
	// entries stay hidden while a frame runs, so the sink never sees half a transaction
	assign wb_valid = fifo_out_valid && !busy;

	always @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= S_IDLE;
			bit_reg <= 4'd0;
			shift_reg <= 8'h00;
			ack_phase_reg <= 1'b0;
			ack_drive_reg <= 1'b0;
			tx_drive_reg <= 1'b0;
			wb_entry_reg <= 16'h0000;
			pointer <= `IPRA_PTR_RESET;
			cache_addr <= `IPRA_PTR_RESET;
			cache_load <= 1'b0;
			busy <= 1'b0;
			fifo_in_valid <= 1'b0;
		end else begin
			cache_load <= 1'b0;
			fifo_in_valid <= 1'b0;
			if (stop_det) begin
				state_reg <= S_IDLE;
				busy <= 1'b0; // queued entries drain only once the frame ends
				ack_drive_reg <= 1'b0;
				tx_drive_reg <= 1'b0;
			end else if (start_det) begin
				if (state_reg == S_IDLE) begin
					state_reg <= S_ADDR;
					busy <= 1'b1;
					cache_load <= 1'b1;
					bit_reg <= 4'd0;
					ack_phase_reg <= 1'b0;
				end else begin
					state_reg <= S_IGNORE;
					ack_drive_reg <= 1'b0;
					tx_drive_reg <= 1'b0;
				end
			end else if (scl_rise && state_reg != S_IDLE && state_reg != S_IGNORE) begin
				if (ack_phase_reg) begin
					if (state_reg == S_RACK) begin
						if (!sda_s_reg) begin
							pointer <= next_word(pointer);
							cache_addr <= next_word(pointer);
							state_reg <= S_RDATA;
						end else begin
							state_reg <= S_IGNORE;
						end
					end
				end else begin
					shift_reg <= byte_in;
					bit_reg <= bit_reg + 4'd1;
				end
			end else if (scl_fall && state_reg != S_IDLE && state_reg != S_IGNORE) begin
				if (ack_phase_reg) begin
					ack_phase_reg <= 1'b0;
					ack_drive_reg <= 1'b0;
					bit_reg <= 4'd0;
					tx_drive_reg <= (state_reg == S_RDATA) && !cache_rdata[7];
					shift_reg <= cache_rdata;
				end else if (state_reg == S_RDATA) begin
					if (bit_reg == 4'd8) begin
						ack_phase_reg <= 1'b1;
						tx_drive_reg <= 1'b0;
						state_reg <= S_RACK;
					end else begin
						// each rising edge shifts the register too, so the next bit to send is the top one
						tx_drive_reg <= !shift_reg[7];
					end
				end else if (bit_reg == 4'd8) begin
					ack_phase_reg <= 1'b1;
					case (state_reg)
						S_ADDR: begin
							if (shift_reg == `IPRA_ADDR_WRITE) begin
								ack_drive_reg <= 1'b1;
								state_reg <= S_PTR;
							end else if (shift_reg == `IPRA_ADDR_READ) begin
								ack_drive_reg <= 1'b1;
								state_reg <= S_RDATA;
								cache_addr <= pointer;
							end else begin
								state_reg <= S_IGNORE;
							end
						end
						S_PTR: begin
							ack_drive_reg <= 1'b1;
							pointer <= shift_reg;
							cache_addr <= shift_reg;
							state_reg <= S_WDATA;
						end
						S_WDATA: begin
							if (fifo_in_ready) begin
								ack_drive_reg <= 1'b1;
								fifo_in_valid <= 1'b1;
								// capture now: cache_addr moves on at this same edge
								wb_entry_reg <= {cache_addr, shift_reg};
								pointer <= next_word(pointer);
								cache_addr <= next_word(pointer);
							end else begin
								state_reg <= S_IGNORE;
							end
						end
						default: begin
							state_reg <= S_IGNORE;
						end
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: ipra_regs.vh
// constants for the paged-register i2c target: addresses, pointer fields, sizes
// assumes inclusion by bare name from the design files
`ifndef IPRA_REGS_VH
`define IPRA_REGS_VH
`define IPRA_ADDR_WRITE 8'hac
`define IPRA_ADDR_READ 8'had
`define IPRA_PAGE_MSB 7
`define IPRA_PAGE_LSB 3
`define IPRA_WORD_MSB 2
`define IPRA_WORD_LSB 0
`define IPRA_PTR_RESET 8'h00
`define IPRA_FIFO_WIDTH 16
`define IPRA_FIFO_DEPTH 32
`define IPRA_FIFO_AW 5
`endif

// File: ipra_fifo.v
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module ipra_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_sys,
	input wire reset,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] cnt_reg;
	wire push;
	wire pop;
	localparam [AW:0] FULL_COUNT = DEPTH;
	assign in_ready = (cnt_reg != FULL_COUNT);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
	always @(posedge clk_sys) begin
		if (reset) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: ipra_target_sva.sv
// port checker for the paged-register i2c target
// assumes binding onto ipra_target, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module ipra_target_sva(
	input wire logic clk_sys, reset, scl_in, sda_out, sda_oe, cache_load, busy,
	input wire logic [7:0] pointer,
	input wire logic wb_valid, wb_ready,
	input wire logic [15:0] wb_data
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_stall;
		wb_valid && !wb_ready;
	endsequence
	a_out_low: assert property (sda_out == 1'b0) else $error("sda driven high");
	a_load_pulse: assert property (cache_load |=> !cache_load) else $error("load too long");
	a_load_busy: assert property (cache_load |-> ##[0:1] busy) else $error("load without busy");
	a_wb_idle: assert property (wb_valid |-> !busy) else $error("write-back in transfer");
	a_wb_hold: assert property (s_stall |=> busy || (wb_valid && $stable(wb_data))) else $error("entry lost");
	a_ptr_idle: assert property (!busy |=> $stable(pointer)) else $error("pointer moved idle");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
	a_busy_scl: assert property ($changed(busy) |-> scl_in) else $error("framing off scl high");
endmodule
bind ipra_target ipra_target_sva sva(.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .cache_load(cache_load), .busy(busy), .pointer(pointer), .wb_valid(wb_valid),
	.wb_ready(wb_ready), .wb_data(wb_data));
`default_nettype wire

// File: ipra_ctrl.sv
// i2c controller model: scl stays high between frames
// assumes the bench resolves sda with a pull-up
`timescale 1ns/10ps
`default_nettype none
module ipra_ctrl(
	output var logic scl,
	output var logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// data changes only while scl is low
	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		#20 scl = 1'b1;
		#20 r = sda;
		#20 scl = 1'b0;
		#20;
	endtask
	task automatic start;
		sda_low = 1'b1;
		#20 scl = 1'b0;
		#20;
	endtask
	task automatic stop;
		sda_low = 1'b1;
		#20 scl = 1'b1;
		#20 sda_low = 1'b0;
		#60;
	endtask
	// msb first, then the ack bit; ai high releases it
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(ai, ao);
	endtask
endmodule
`default_nettype wire

// File: i2c_paged_register_access_tb.sv
// bench: controller model on the pins, cache and write-back sink here
// assumes ipra_target, ipra_ctrl and the bound checker
`timescale 1ns/10ps
`default_nettype none
module i2c_paged_register_access_tb;
	logic clk_sys, reset, scl, sda_low, busy, sda_out, sda_oe, cache_load, wb_valid, ak;
	logic wb_ready = 1'b0;
	logic [7:0] cache_addr, pointer, q, p, d;
	logic [2:0] w;
	logic [15:0] wb_data;
	logic [15:0] wq[$];
	int err_count, total_checks, cyc, loads, seed = 7186;
	wire logic sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
	ipra_target dut(.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .cache_load(cache_load), .cache_addr(cache_addr), .cache_rdata(cache_addr ^ 8'h5a),
		.wb_valid(wb_valid), .wb_ready(wb_ready), .wb_data(wb_data), .pointer(pointer), .busy(busy));
	ipra_ctrl m(.scl(scl), .sda_low(sda_low), .sda(sda));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		total_checks++;
		if (a !== e) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, a, e);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic sb(input logic [7:0] b, input logic ea);
		m.xfer(b, 1'b1, q, ak);
		chk(ak, ea);
	endtask
	// sink stalls at random while entries are compared in order
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			results();
		end else begin
			if (cache_load === 1'b1 && !reset)
				loads++;
			if (wb_valid === 1'b1 && wb_ready && !reset)
				chk(wb_data, wq.pop_front());
			#1 wb_ready = $random(seed);
		end
	end
	initial begin
		reset = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk(pointer, 8'h00);
		for (int t = 0; t < 2; t++) begin
			p = $random(seed);
			w = 3'h6;
			m.start();
			chk(busy, 1);
			sb(8'hac, 0);
			sb({p[7:3], w}, 0);
			repeat (3) begin
				d = $random(seed);
				wq.push_back({p[7:3], w, d});
				sb(d, 0);
				w = w + 3'h1;
			end
			m.stop();
			chk(busy, 0);
			chk(pointer, {p[7:3], w});
			p = $random(seed);
			w = p[2:0];
			m.start();
			sb(8'hac, 0);
			sb(p, 0);
			m.stop();
			m.start();
			sb(8'had, 0);
			for (int i = 0; i < 3; i++) begin
				m.xfer(8'hff, i == 2, q, ak);
				chk(q, {p[7:3], w} ^ 8'h5a);
				if (i < 2)
					w = w + 3'h1;
			end
			chk(sda_oe, 0);
			m.stop();
			m.start();
			sb(8'had, 0);
			m.xfer(8'hff, 1'b1, q, ak);
			chk(q, {p[7:3], w} ^ 8'h5a);
			m.stop();
			m.start();
			sb({4'h3, p[3:0]}, 1);
			sb(p, 1);
			m.stop();
			chk(pointer, {p[7:3], w});
			$display("round %0d done", t);
		end
		repeat (60) @(posedge clk_sys);
		chk(16'(wq.size()), 0);
		chk(16'(loads), 16'd10);
		results();
	end
endmodule
`default_nettype wire
